// ---- dtr_burst_timer.sv ----
`timescale 1ns/10ps
module dtr_burst_timer #(
  parameter int TICKS = dtr_pkg::BURST_TICKS
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic long_i,
  input wire logic tick_i,
  input wire logic abort_i,
  output logic burst_o,
  output logic busy_o,
  output logic done_o
);
  import dtr_pkg::*;

  localparam int CNT_W = $clog2(TICKS * CP_BURST_FACTOR + 1);

  typedef enum logic [1:0] {T_IDLE, T_BURST, T_PAUSE} dtr_tstate_t;

  dtr_tstate_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] len_r;

  initial begin
    if (TICKS < 1) begin
      $error("dtr_burst_timer: TICKS must be at least 1");
    end
  end

  assign burst_o = (state_r == T_BURST);
  assign busy_o = (state_r != T_IDLE);

  // ------------------------------------------------------------
  // Burst then equal pause, both counted in oscillator ticks
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_r <= T_IDLE;
      cnt_r <= '0;
      len_r <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        state_r <= T_IDLE;
        cnt_r <= '0;
      end else if (start_i) begin
        // A new write restarts the burst with fresh timing
        state_r <= T_BURST;
        cnt_r <= '0;
        len_r <= long_i ? CNT_W'(TICKS * CP_BURST_FACTOR) : CNT_W'(TICKS);
      end else begin
        case (state_r)
          T_IDLE: begin
            cnt_r <= '0;
          end
          T_BURST, T_PAUSE: begin
            if (tick_i) begin
              if (cnt_r == len_r - 1'b1) begin
                cnt_r <= '0;
                if (state_r == T_BURST) begin
                  state_r <= T_PAUSE;
                end else begin
                  state_r <= T_IDLE;
                  done_o <= 1'b1;
                end
              end else begin
                cnt_r <= cnt_r + 1'b1;
              end
            end
          end
          default: begin
            state_r <= T_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ---- dtr_host_model.sv ----
`timescale 1ns/10ps
module dtr_host_model (
  input wire logic clk_i,
  input wire logic [3:0] bus_i,
  output logic phi2_o,
  output logic cs_n_o,
  output logic rs_o,
  output logic rw_o,
  output logic [3:0] data_o
);
  initial begin
    phi2_o = 1'b0;
    cs_n_o = 1'b1;
    rs_o = 1'b0;
    rw_o = 1'b1;
    data_o = 4'h5;
  end
  // ------------------------------------------------------------
  // One bus cycle, pins held until the strobe has been seen low
  // ------------------------------------------------------------
  // Undriven bus shows the inverse of its last value, never a stale copy
  task automatic xfer(input logic rs, input logic rw, input logic [3:0] wd,
                      output logic [3:0] rd);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    rs_o = rs;
    rw_o = rw;
    data_o = rw ? ~data_o : wd;
    phi2_o = 1'b1;
    // Read data taken mid-cycle, well after the block has settled it
    repeat (5) @(negedge clk_i);
    rd = bus_i;
    phi2_o = 1'b0;
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    data_o = ~data_o;
  endtask
endmodule

// ---- dtr_host_regs.sv ----
`timescale 1ns/10ps
// Overview of operation
// - Select line and R/W pick four accesses
// - Receive digit holds last validated pair code
// - Transmit digit is write only, picks tones
// - Select bit routes next control write to B
// - Control A bit 0 gates the tone output
// - Call-progress mode, bit 1, stops receive latching
// - Call-progress plus enable puts wave on pin
// - Call-progress burst and pause last 102 ms
// - Interrupt enable pulls pin on rx or ready
// - Burst mode: burst, equal pause, then ready
// - Tone-pair burst and pause last 51 ms
// - Non-burst: host times tone by output enable
// - Test bit shows inverted steering, tone-pair only
// - Control B selects single tone, row or column
// - Status bit 0 follows bits 1, 2; read clears
// - Status bit 1 ready after pause; read clears
// - Status bit 2 set on receive latch; read clears
// - Status bit 3 tracks validated tone absence
// - Interrupt pin only pulls low or releases
// - Digit codes follow the standard keypad table
module dtr_host_regs #(
  parameter int BURST_TICKS_P = dtr_pkg::BURST_TICKS
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // Processor bus pins
  input wire logic phi2_i,
  input wire logic cs_n_i,
  input wire logic register_select_line_i,
  input wire logic rw_i,
  input wire logic [3:0] data_i,
  output logic [3:0] data_o,
  output logic data_oe_o,
  // Tone oscillator, sampled here
  input wire logic tone_osc_i,
  // Receiver side, same clock domain
  input wire logic [3:0] rx_code_i,
  input wire logic delayed_steer_i,
  input wire logic cp_wave_i,
  // Transmitter side
  output dtr_pkg::dtr_tone_t tone_o,
  // Open-drain interrupt or tone pin
  output logic interrupt_or_tone_pin_o,
  output logic interrupt_or_tone_pin_oe_o
);
  import dtr_pkg::*;

  initial begin
    if (BURST_TICKS_P < 1) begin
      $error("dtr_host_regs: BURST_TICKS_P must be at least 1");
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  dtr_bus_t bus_raw;
  dtr_bus_t bus_s;
  logic phi2_s;
  logic osc_s;

  assign bus_raw = '{cs_n: cs_n_i, reg_sel: register_select_line_i, rw: rw_i, data: data_i};

  dtr_sync2 #(
    .WIDTH($bits(dtr_bus_t) + 1)
  ) u_bus_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i({phi2_i, bus_raw}),
    .sync_o({phi2_s, bus_s})
  );

  dtr_sync2 #(
    .WIDTH(1)
  ) u_osc_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i(tone_osc_i),
    .sync_o(osc_s)
  );

  // ------------------------------------------------------------
  // Edge detection
  // ------------------------------------------------------------
  logic phi2_d_r;
  logic osc_d_r;
  logic steer_d_r;
  logic osc_tick;
  logic access_end;
  logic steer_rise;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      phi2_d_r <= 1'b0;
      osc_d_r <= 1'b0;
      steer_d_r <= 1'b0;
    end else begin
      phi2_d_r <= phi2_s;
      osc_d_r <= osc_s;
      steer_d_r <= delayed_steer_i;
    end
  end

  assign osc_tick = osc_s & ~osc_d_r;
  // Bus cycle completes on the falling edge of the strobe
  assign access_end = phi2_d_r & ~phi2_s & ~bus_s.cs_n;
  assign steer_rise = delayed_steer_i & ~steer_d_r;

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  logic wr_tx;
  logic wr_ctrl;
  logic rd_status;

  assign wr_tx = access_end & (bus_s.reg_sel == REG_SEL_DATA) & ~bus_s.rw;
  assign wr_ctrl = access_end & (bus_s.reg_sel == REG_SEL_CTRL) & ~bus_s.rw;
  assign rd_status = access_end & (bus_s.reg_sel == REG_SEL_CTRL) & bus_s.rw;

  // ------------------------------------------------------------
  // Control registers sharing one address
  // ------------------------------------------------------------
  dtr_ctrl_a_t control_reg_a_r;
  dtr_ctrl_b_t control_reg_b_r;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      control_reg_a_r <= dtr_ctrl_a_t'(CTRL_RESET);
      control_reg_b_r <= dtr_ctrl_b_t'(CTRL_RESET);
    end else if (wr_ctrl) begin
      if (control_reg_a_r.sel_b) begin
        control_reg_b_r <= dtr_ctrl_b_t'(bus_s.data);
        // One-shot redirect: following writes land in A again
        control_reg_a_r.sel_b <= 1'b0;
      end else begin
        control_reg_a_r <= dtr_ctrl_a_t'(bus_s.data);
      end
    end
  end

  logic cp_mode;
  logic burst_mode;

  assign cp_mode = control_reg_a_r.cp_mode;
  assign burst_mode = ~control_reg_b_r.non_burst;

  // ------------------------------------------------------------
  // Transmit path
  // ------------------------------------------------------------
  logic [3:0] transmit_digit_r;
  logic tx_burst;
  logic tx_busy;
  logic tx_done;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      transmit_digit_r <= DIGIT_RESET;
    end else if (wr_tx) begin
      // Code passes as written; the synthesiser maps it to tones
      transmit_digit_r <= bus_s.data;
    end
  end

  dtr_burst_timer #(
    .TICKS(BURST_TICKS_P)
  ) u_burst (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(wr_tx & burst_mode),
    .long_i(cp_mode),
    .tick_i(osc_tick),
    .abort_i(~burst_mode),
    .burst_o(tx_burst),
    .busy_o(tx_busy),
    .done_o(tx_done)
  );

  dtr_tone_t tone_r;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tone_r <= '0;
    end else begin
      tone_r.digit <= transmit_digit_r;
      // Non-burst: the host gates duration with the enable bit
      tone_r.enable <= control_reg_a_r.tone_en & (~burst_mode | tx_burst);
      tone_r.single <= control_reg_b_r.single;
      tone_r.column <= control_reg_b_r.column;
    end
  end

  assign tone_o = tone_r;

  // ------------------------------------------------------------
  // Receive path
  // ------------------------------------------------------------
  logic [3:0] receive_digit_r;
  logic rx_latch;

  // Call-progress mode suppresses receive latching; steering still reaches status bit 3
  assign rx_latch = steer_rise & ~cp_mode;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      receive_digit_r <= DIGIT_RESET;
    end else if (rx_latch) begin
      receive_digit_r <= rx_code_i;
    end
  end

  // ------------------------------------------------------------
  // Status flags: a set in the clearing cycle wins
  // ------------------------------------------------------------
  dtr_status_t status_r;
  dtr_status_t status_nxt;
  logic tx_ready_evt;

  assign tx_ready_evt = tx_done & burst_mode;

  always_comb begin
    status_nxt = status_r;
    if (rd_status) begin
      status_nxt.irq = 1'b0;
      status_nxt.tx_empty = 1'b0;
      status_nxt.rx_full = 1'b0;
    end
    if (tx_ready_evt) begin
      status_nxt.tx_empty = 1'b1;
    end
    if (!burst_mode) begin
      status_nxt.tx_empty = 1'b0;
    end
    if (rx_latch) begin
      status_nxt.rx_full = 1'b1;
    end
    if (tx_ready_evt | rx_latch) begin
      status_nxt.irq = 1'b1;
    end
    // Unaffected by reads; the inverse of the steering level
    status_nxt.steer_absent = ~delayed_steer_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [3:0] data_r;

  // Frozen at strobe fall, so a read sees flags before the clear
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      data_r <= '0;
    end else if (phi2_s) begin
      data_r <= (bus_s.reg_sel == REG_SEL_CTRL) ? status_r : receive_digit_r;
    end
  end

  assign data_o = data_r;
  assign data_oe_o = phi2_s & phi2_d_r & ~bus_s.cs_n & bus_s.rw;

  // ------------------------------------------------------------
  // Interrupt or tone pin
  // ------------------------------------------------------------
  logic pin_low_r;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pin_low_r <= 1'b0;
    end else if (control_reg_b_r.test & ~cp_mode) begin
      pin_low_r <= delayed_steer_i;
    end else if (control_reg_a_r.irq_en & cp_mode) begin
      pin_low_r <= ~cp_wave_i;
    end else if (control_reg_a_r.irq_en) begin
      pin_low_r <= status_nxt.irq;
    end else begin
      pin_low_r <= 1'b0;
    end
  end

  // Never drives high; the board pull-up supplies the idle level
  assign interrupt_or_tone_pin_o = 1'b0;
  assign interrupt_or_tone_pin_oe_o = pin_low_r;

endmodule

// ---- dtr_host_regs_props.sv ----
`timescale 1ns/10ps
module dtr_host_regs_props #(
  parameter int BURST_TICKS_P = dtr_pkg::BURST_TICKS
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic phi2_i,
  input wire logic cs_n_i,
  input wire logic register_select_line_i,
  input wire logic rw_i,
  input wire logic [3:0] data_i,
  input wire logic [3:0] data_o,
  input wire logic data_oe_o,
  input wire logic tone_osc_i,
  input wire logic [3:0] rx_code_i,
  input wire logic delayed_steer_i,
  input wire logic cp_wave_i,
  input wire dtr_pkg::dtr_tone_t tone_o,
  input wire logic interrupt_or_tone_pin_o,
  input wire logic interrupt_or_tone_pin_oe_o
);
  import dtr_pkg::*;
  logic [2:0] ph_r;
  logic [1:0] cs_r, rs_r, rw_r, q_r;
  logic [7:0] d_r;
  logic [3:0] ctla_r, ctlb_r, txd_r;
  logic sel_r, tk, st;
  // ------------------------------------------------------------
  // Shadow of the control registers
  // ------------------------------------------------------------
  // Same two-flop view of the pins as the block, so writes land together
  assign tk = ph_r[2] && !ph_r[1] && !cs_r[1] && !rw_r[1];
  assign st = q_r == 2'h3;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ph_r <= 3'h0;
      cs_r <= 2'h0;
      rs_r <= 2'h0;
      rw_r <= 2'h0;
      d_r <= 8'h00;
    end else begin
      ph_r <= {ph_r[1:0], phi2_i};
      cs_r <= {cs_r[0], cs_n_i};
      rs_r <= {rs_r[0], register_select_line_i};
      rw_r <= {rw_r[0], rw_i};
      d_r <= {d_r[3:0], data_i};
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctla_r <= 4'h0;
      ctlb_r <= 4'h0;
      txd_r <= 4'h0;
      sel_r <= 1'b0;
    end else if (tk) begin
      if (!rs_r[1]) begin
        txd_r <= d_r[7:4];
      end else if (sel_r) begin
        ctlb_r <= d_r[7:4];
      end else begin
        ctla_r <= d_r[7:4];
      end
      sel_r <= rs_r[1] ? (!sel_r && d_r[7]) : sel_r;
    end
  end
  // Settled three edges after the last write, covering output latency
  always_ff @(posedge clk_i) begin
    if (!rstn_i || tk) begin
      q_r <= 2'h0;
    end else if (!st) begin
      q_r <= q_r + 2'h1;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_open_drain: assert property (interrupt_or_tone_pin_o == 1'b0)
    else $error("interrupt pin data not low");
  a_read_drive: assert property (data_oe_o |->
    $past(phi2_i, 2) && $past(rw_i, 2) && !$past(cs_n_i, 2))
    else $error("bus driven outside a read");
  a_tone_gate: assert property (tone_o.enable |->
    ctla_r[0] || $past(ctla_r[0]) || $past(ctla_r[0], 2))
    else $error("tone on while output disabled");
  a_tone_fields: assert property (st |-> tone_o.single == ctlb_r[2] &&
    tone_o.column == ctlb_r[3] && tone_o.digit == txd_r)
    else $error("tone fields differ from control");
  a_non_burst: assert property (st && ctlb_r[0] |-> tone_o.enable == ctla_r[0])
    else $error("non-burst tone not following enable");
  a_pin_test: assert property (st && ctlb_r[1] && !ctla_r[1] |->
    interrupt_or_tone_pin_oe_o == $past(delayed_steer_i))
    else $error("test pin not showing steering");
  a_cp_wave: assert property (st && ctla_r[2] && ctla_r[1] |->
    interrupt_or_tone_pin_oe_o == !$past(cp_wave_i))
    else $error("pin not following call progress wave");
  a_pin_quiet: assert property (st && !ctla_r[2] && !(ctlb_r[1] && !ctla_r[1]) |->
    !interrupt_or_tone_pin_oe_o)
    else $error("pin pulled with interrupts off");
endmodule

bind dtr_host_regs dtr_host_regs_props #(.BURST_TICKS_P(BURST_TICKS_P)) u_props (
  .clk_i(clk_i),
  .rstn_i(rstn_i),
  .phi2_i(phi2_i),
  .cs_n_i(cs_n_i),
  .register_select_line_i(register_select_line_i),
  .rw_i(rw_i),
  .data_i(data_i),
  .data_o(data_o),
  .data_oe_o(data_oe_o),
  .tone_osc_i(tone_osc_i),
  .rx_code_i(rx_code_i),
  .delayed_steer_i(delayed_steer_i),
  .cp_wave_i(cp_wave_i),
  .tone_o(tone_o),
  .interrupt_or_tone_pin_o(interrupt_or_tone_pin_o),
  .interrupt_or_tone_pin_oe_o(interrupt_or_tone_pin_oe_o)
);

// ---- dtr_pkg.sv ----
package dtr_pkg;

  // ------------------------------------------------------------
  // Bus decode and field layout
  // ------------------------------------------------------------
  localparam logic REG_SEL_DATA = 1'b0;
  localparam logic REG_SEL_CTRL = 1'b1;
  localparam int DATA_W = 4;
  localparam int CTLA_TONE_EN_BIT = 0;
  localparam int CTLA_CP_MODE_BIT = 1;
  localparam int CTLA_IRQ_EN_BIT = 2;
  localparam int CTLA_SEL_B_BIT = 3;
  localparam int CTLB_NON_BURST_BIT = 0;
  localparam int CTLB_TEST_BIT = 1;
  localparam int CTLB_SINGLE_BIT = 2;
  localparam int CTLB_COLUMN_BIT = 3;
  localparam int STAT_IRQ_BIT = 0;
  localparam int STAT_TX_EMPTY_BIT = 1;
  localparam int STAT_RX_FULL_BIT = 2;
  localparam int STAT_STEER_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] DIGIT_RESET = 4'h0;

  // ------------------------------------------------------------
  // Burst timing, counted in tone oscillator periods
  // ------------------------------------------------------------
  localparam longint TONE_OSC_HZ = 3579545;
  localparam longint BURST_TIME_US = 51000;
  localparam longint BURST_TICKS_L = BURST_TIME_US * TONE_OSC_HZ / 1000000;
  localparam int BURST_TICKS = int'(BURST_TICKS_L);
  localparam int CP_BURST_FACTOR = 2;

  typedef struct packed {
    logic cs_n;
    logic reg_sel;
    logic rw;
    logic [3:0] data;
  } dtr_bus_t;

  typedef struct packed {
    logic sel_b;
    logic irq_en;
    logic cp_mode;
    logic tone_en;
  } dtr_ctrl_a_t;

  typedef struct packed {
    logic column;
    logic single;
    logic test;
    logic non_burst;
  } dtr_ctrl_b_t;

  typedef struct packed {
    logic steer_absent;
    logic rx_full;
    logic tx_empty;
    logic irq;
  } dtr_status_t;

  typedef struct packed {
    logic [3:0] digit;
    logic enable;
    logic single;
    logic column;
  } dtr_tone_t;

endpackage

// ---- dtr_sync2.sv ----
`timescale 1ns/10ps
module dtr_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;

  initial begin
    if (WIDTH < 1) begin
      $error("dtr_sync2: WIDTH must be at least 1");
    end
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import dtr_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic osc = 1'b0;
  logic [3:0] rx_code = 4'h0;
  logic steer = 1'b0;
  logic cp_wave = 1'b0;
  logic phi2, cs_n, rs, rw, oe, pin, pin_oe;
  logic [3:0] hd, dd, bus, rd;
  dtr_tone_t tone;
  int n_errors = 0;
  int checked = 0;
  always #5 clk_i = ~clk_i;
  always #62.5 osc = ~osc;
  assign bus = oe ? dd : hd;
  dtr_host_regs #(.BURST_TICKS_P(8)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .phi2_i(phi2),
    .cs_n_i(cs_n), .register_select_line_i(rs), .rw_i(rw), .data_i(bus), .data_o(dd),
    .data_oe_o(oe), .tone_osc_i(osc), .rx_code_i(rx_code), .delayed_steer_i(steer),
    .cp_wave_i(cp_wave), .tone_o(tone), .interrupt_or_tone_pin_o(pin),
    .interrupt_or_tone_pin_oe_o(pin_oe));
  dtr_host_model host (.clk_i(clk_i), .bus_i(bus), .phi2_o(phi2), .cs_n_o(cs_n),
    .rs_o(rs), .rw_o(rw), .data_o(hd));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wr(input logic r, input logic [3:0] d);
    host.xfer(r, 1'b0, d, rd);
  endtask
  task automatic rchk(input logic r, input logic [3:0] e);
    host.xfer(r, 1'b1, 4'h0, rd);
    chk({4'h0, rd}, {4'h0, e});
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_soft_reset();
    host.xfer(1'b1, 1'b1, 4'h0, rd);
    wr(1'b1, 4'h0);
    wr(1'b1, 4'h0);
    wr(1'b1, 4'h8);
    wr(1'b1, 4'h0);
    rchk(1'b1, 4'h8);
    chk({7'h0, tone.enable}, 8'h0);
    $display("soft reset done");
  endtask
  task automatic t_receive();
    wr(1'b1, 4'h4);
    rx_code = 4'hA;
    steer = 1'b1;
    cyc(3);
    chk({7'h0, pin_oe}, 8'h1);
    rchk(1'b1, 4'h5);
    cyc(2);
    chk({7'h0, pin_oe}, 8'h0);
    rchk(1'b0, 4'hA);
    steer = 1'b0;
    cyc(3);
    rchk(1'b1, 4'h8);
    wr(1'b1, 4'h2);
    rx_code = 4'h3;
    steer = 1'b1;
    cyc(3);
    steer = 1'b0;
    cyc(3);
    rchk(1'b0, 4'hA);
    rchk(1'b1, 4'h8);
    $display("receive done");
  endtask
  // Burst length in clock cycles is ticks times 12.5
  // First tick lands anywhere in one oscillator period, so allow one tick short
  task automatic t_burst(input logic [3:0] ctla, input int exp, input logic [3:0] dig);
    int n;
    wr(1'b1, ctla);
    wr(1'b1, 4'h0);
    wr(1'b0, dig);
    n = 0;
    while (!tone.enable && n < 400) begin
      cyc(1);
      n++;
    end
    chk({4'h0, tone.digit}, {4'h0, dig});
    n = 0;
    while (tone.enable && n < 400) begin
      cyc(1);
      n++;
    end
    chk({7'h0, n >= exp - 14 && n <= exp + 1}, 8'h1);
    cyc(exp - 20);
    rchk(1'b1, 4'h8);
    cyc(20);
    chk({7'h0, pin_oe}, {7'h0, ctla[2]});
    rchk(1'b1, 4'hB);
    $display("burst done");
  endtask
  task automatic t_modes();
    wr(1'b1, 4'h9);
    wr(1'b1, 4'h5);
    cyc(3);
    chk({7'h0, tone.enable}, 8'h1);
    chk({6'h0, tone.single, tone.column}, 8'h2);
    rchk(1'b1, 4'h8);
    wr(1'b1, 4'h8);
    wr(1'b1, 4'hE);
    cyc(3);
    chk({7'h0, tone.enable}, 8'h0);
    chk({6'h0, tone.single, tone.column}, 8'h3);
    steer = 1'b1;
    cyc(2);
    chk({7'h0, pin_oe}, 8'h1);
    steer = 1'b0;
    cyc(2);
    chk({7'h0, pin_oe}, 8'h0);
    wr(1'b1, 4'h6);
    cp_wave = 1'b1;
    cyc(2);
    chk({7'h0, pin_oe}, 8'h0);
    cp_wave = 1'b0;
    cyc(2);
    chk({7'h0, pin_oe}, 8'h1);
    $display("modes done");
  endtask
  initial begin
    repeat (3) @(negedge clk_i);
    rstn_i = 1'b1;
    cyc(3);
    t_soft_reset();
    t_receive();
    t_burst(4'hD, 100, 4'h7);
    t_burst(4'hB, 200, 4'hC);
    t_modes();
    stop_test();
  end
  // Whole run needs well under 100 us
  initial begin
    #500000;
    n_errors++;
    stop_test();
  end
endmodule
